// file: rtl/pmc_pkg.sv
// Purpose: Shared constants for the power mode control register bank.
// Assumes: 32-bit peripheral bus data, word-aligned register offsets.
// Notes:   Field positions are bit indices within each 32-bit register.
package pmc_pkg;

  localparam int unsigned PMC_ADDR_W  = 8;
  localparam int unsigned PMC_DATA_W  = 32;
  localparam int unsigned PMC_WAKE_N  = 8;
  localparam int unsigned PMC_THR_W   = 3;

  // Register offsets (byte addresses).
  localparam logic [PMC_ADDR_W-1:0] PMC_CTRL_OFS = 8'h00;
  localparam logic [PMC_ADDR_W-1:0] PMC_STAT_OFS = 8'h04;

  // Reset values.
  localparam logic [PMC_DATA_W-1:0] PMC_CTRL_RST = 32'h00000000;
  localparam logic [PMC_DATA_W-1:0] PMC_STAT_RST = 32'h00000000;

  // Control register fields.
  localparam int unsigned PMC_CTRL_LPSEL_BIT  = 0;
  localparam int unsigned PMC_CTRL_PDSEL_BIT  = 1;
  localparam int unsigned PMC_CTRL_WCLR_BIT   = 2;
  localparam int unsigned PMC_CTRL_SCLR_BIT   = 3;
  localparam int unsigned PMC_CTRL_DETEN_BIT  = 4;
  localparam int unsigned PMC_CTRL_THR_LSB    = 5;
  localparam int unsigned PMC_CTRL_BKWE_BIT   = 8;

  // Status register fields.
  localparam int unsigned PMC_STAT_WAKE_BIT   = 0;
  localparam int unsigned PMC_STAT_STBY_BIT   = 1;
  localparam int unsigned PMC_STAT_DET_BIT    = 2;
  localparam int unsigned PMC_STAT_WPCFG_LSB  = 8;

  // Timing: wake flag clears this many clocks after the write of 1.
  localparam int unsigned PMC_WCLR_DELAY      = 2;
  // Extra wait states: every access has one, a status read one more.
  localparam logic [1:0]  PMC_WAIT_STD        = 2'h0;
  localparam logic [1:0]  PMC_WAIT_STAT_RD    = 2'h1;

endpackage : pmc_pkg

// file: rtl/pmc_sync.sv
// Purpose: Two-flop synchroniser for a bundle of asynchronous levels.
// Assumes: Each bit is an independent level; no word coherency is implied.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps
`default_nettype none
module pmc_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= i_async;
      sync_r <= meta_r;
    end
  end

  assign o_sync = sync_r;

endmodule // pmc_sync
`default_nettype wire

// file: rtl/pmc_regs.sv
// Purpose: Power mode control and status registers on the peripheral bus.
// Assumes: APB3 slave on i_clk; pins and alarm are asynchronous levels.
// Notes:   i_rst_n is the power-on/off reset and clears everything.
//
// Summary of operation
// - Control register resets to zero, also on wake from standby.
// - Bit 0 puts the regulator into low power during stop mode.
// - Bit 1 selects standby (1) or stop (0) as deep-sleep target.
// - Writing 1 to bit 2 clears the wake flag two clocks later.
// - Writing 1 to bit 3 clears the standby flag; 0 does nothing.
// - Bit 4 switches the supply-voltage detector on or off.
// - Bits 7:5 pick detector threshold, 2.2V to 2.9V in 100 mV steps.
// - Bit 8 allows backup-domain writes; blocked after reset.
// - Status register resets to zero but survives a standby wake.
// - Status register reads take one extra bus wait cycle.
// - Wake flag sets on an enabled wake pin high or clock alarm.
// - Standby flag sets on standby entry; cleared only by power reset or clear bit.
// - Detector flag is 1 when supply below threshold, valid when enabled.
// - Detector flag reads 0 after reset and on standby entry.
// - Wake pin configure bits 15:8 let each pin wake from standby.
// - A system reset clears all wake pin configure bits.
`timescale 1ns/1ps
`default_nettype none
module pmc_regs
  import pmc_pkg::*;
#(
  parameter int unsigned WAKE_N = pmc_pkg::PMC_WAKE_N
) (
  input  wire logic                             i_clk,
  input  wire logic                             i_rst_n,
  // Peripheral bus slave.
  input  wire logic                             i_psel,
  input  wire logic                             i_penable,
  input  wire logic                             i_pwrite,
  input  wire logic [pmc_pkg::PMC_ADDR_W-1:0]   i_paddr,
  input  wire logic [pmc_pkg::PMC_DATA_W-1:0]   i_pwdata,
  output logic      [pmc_pkg::PMC_DATA_W-1:0]   o_prdata,
  output logic                                  o_pready,
  output logic                                  o_pslverr,
  // Reset sources other than power-on/off, synchronous one-cycle pulses.
  input  wire logic                             i_system_reset,
  input  wire logic                             i_standby_wake,
  // Core low-power handshake, synchronous.
  input  wire logic                             i_core_deep_sleep_select,
  input  wire logic                             i_wait_exec,
  // Asynchronous inputs.
  input  wire logic [WAKE_N-1:0]                i_wake_pin,
  input  wire logic                             i_alarm_wake,
  input  wire logic                             i_detector_below,
  // Controls to the power domain.
  output logic                                  o_regulator_lowpower,
  output logic                                  o_stop_entry,
  output logic                                  o_standby_entry,
  output logic                                  o_detector_enable,
  output logic      [pmc_pkg::PMC_THR_W-1:0]    o_detector_threshold,
  output logic                                  o_backup_write_enable,
  output logic      [WAKE_N-1:0]                o_wake_pin_enable,
  output logic                                  o_wake_request
);

  // Control register state.
  logic                 lp_sel_r;
  logic                 pd_sel_r;
  logic                 det_en_r;
  logic [PMC_THR_W-1:0] det_thr_r;
  logic                 bk_we_r;
  // Status register state.
  logic                 wake_flag_r;
  logic                 stby_flag_r;
  logic                 det_flag_r;
  logic [WAKE_N-1:0]    wp_cfg_r;
  // Wake flag clear pipeline.
  logic [PMC_WCLR_DELAY-1:0] wclr_pipe_r;
  // Bus slave state.
  logic [1:0]           wait_cnt_r;
  logic                 pready_r;
  logic                 pslverr_r;
  logic [PMC_DATA_W-1:0] prdata_r;
  // Output registers.
  logic                 stop_entry_r;
  logic                 stby_entry_r;
  logic                 wake_req_r;

  // Synchronised asynchronous inputs.
  logic [WAKE_N-1:0]    wake_pin_s;
  logic                 alarm_s;
  logic                 below_s;

  pmc_sync #(
    .W (WAKE_N + 2)
  ) u_sync (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_async ({i_wake_pin, i_alarm_wake, i_detector_below}),
    .o_sync  ({wake_pin_s, alarm_s, below_s})
  );

  // Address decode and bus phase.
  wire                  acc_phase    = i_psel & i_penable & ~pready_r;
  wire                  hit_ctrl     = (i_paddr == PMC_CTRL_OFS);
  wire                  hit_stat     = (i_paddr == PMC_STAT_OFS);
  wire                  hit_any      = hit_ctrl | hit_stat;
  // A status read holds the bus one cycle longer than any other access.
  wire [1:0]            wait_need    = (hit_stat & ~i_pwrite) ? PMC_WAIT_STAT_RD
                                                              : PMC_WAIT_STD;
  wire                  acc_done     = acc_phase & (wait_cnt_r == wait_need);
  wire                  wr_ctrl      = acc_done & i_pwrite & hit_ctrl;
  wire                  wr_stat      = acc_done & i_pwrite & hit_stat;

  // Write-one strobes; a 0 in either bit leaves the flags alone.
  wire                  wclr_req     = wr_ctrl & i_pwdata[PMC_CTRL_WCLR_BIT];
  wire                  sclr_req     = wr_ctrl & i_pwdata[PMC_CTRL_SCLR_BIT];

  // Read-back images; strobe bits and reserved bits read as zero.
  wire [PMC_DATA_W-1:0] ctrl_img     = {23'h000000, bk_we_r, det_thr_r, det_en_r,
                                        2'h0, pd_sel_r, lp_sel_r};
  wire [PMC_DATA_W-1:0] stat_img     = {16'h0000, wp_cfg_r, 5'h00, det_flag_r,
                                        stby_flag_r, wake_flag_r};
  wire [PMC_DATA_W-1:0] rd_mux       = hit_ctrl ? ctrl_img :
                                       hit_stat ? stat_img : PMC_STAT_RST;

  // Wake sources: only pins whose configure bit is set can wake.
  wire                  pin_wake     = |(wake_pin_s & wp_cfg_r);
  wire                  wake_event   = pin_wake | alarm_s;

  // Deep-sleep entry; standby is refused while the wake flag is still set.
  wire                  deep_sleep   = i_wait_exec & i_core_deep_sleep_select;
  wire                  enter_stby   = deep_sleep & pd_sel_r & ~wake_flag_r;
  wire                  enter_stop   = deep_sleep & ~pd_sel_r;

  // Control register is cleared by power reset, system reset or standby wake.
  wire                  ctrl_clear   = i_system_reset | i_standby_wake;

  // Next values for the status flags.
  logic                 wake_flag_nxt;
  logic                 stby_flag_nxt;
  logic                 det_flag_nxt;
  logic [WAKE_N-1:0]    wp_cfg_nxt;

  always_comb begin
    // The set wins over a clear landing in the same cycle.
    wake_flag_nxt = wake_flag_r;
    if (wclr_pipe_r[PMC_WCLR_DELAY-1]) begin
      wake_flag_nxt = 1'b0;
    end
    if (wake_event) begin
      wake_flag_nxt = 1'b1;
    end

    stby_flag_nxt = stby_flag_r;
    if (sclr_req) begin
      stby_flag_nxt = 1'b0;
    end
    if (enter_stby) begin
      stby_flag_nxt = 1'b1;
    end

    // The detector stops in standby, so its flag drops on entry.
    det_flag_nxt = det_en_r & below_s & ~enter_stby;

    wp_cfg_nxt = wp_cfg_r;
    if (wr_stat) begin
      wp_cfg_nxt = i_pwdata[PMC_STAT_WPCFG_LSB +: WAKE_N];
    end
    if (i_system_reset) begin
      wp_cfg_nxt = '0;
    end
  end

  // Control register.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lp_sel_r  <= PMC_CTRL_RST[PMC_CTRL_LPSEL_BIT];
      pd_sel_r  <= PMC_CTRL_RST[PMC_CTRL_PDSEL_BIT];
      det_en_r  <= PMC_CTRL_RST[PMC_CTRL_DETEN_BIT];
      det_thr_r <= PMC_CTRL_RST[PMC_CTRL_THR_LSB +: PMC_THR_W];
      bk_we_r   <= PMC_CTRL_RST[PMC_CTRL_BKWE_BIT];
    end else if (ctrl_clear) begin
      lp_sel_r  <= PMC_CTRL_RST[PMC_CTRL_LPSEL_BIT];
      pd_sel_r  <= PMC_CTRL_RST[PMC_CTRL_PDSEL_BIT];
      det_en_r  <= PMC_CTRL_RST[PMC_CTRL_DETEN_BIT];
      det_thr_r <= PMC_CTRL_RST[PMC_CTRL_THR_LSB +: PMC_THR_W];
      bk_we_r   <= PMC_CTRL_RST[PMC_CTRL_BKWE_BIT];
    end else if (wr_ctrl) begin
      lp_sel_r  <= i_pwdata[PMC_CTRL_LPSEL_BIT];
      pd_sel_r  <= i_pwdata[PMC_CTRL_PDSEL_BIT];
      det_en_r  <= i_pwdata[PMC_CTRL_DETEN_BIT];
      det_thr_r <= i_pwdata[PMC_CTRL_THR_LSB +: PMC_THR_W];
      bk_we_r   <= i_pwdata[PMC_CTRL_BKWE_BIT];
    end
  end

  // Status register; a standby wake leaves it untouched.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wake_flag_r <= PMC_STAT_RST[PMC_STAT_WAKE_BIT];
      stby_flag_r <= PMC_STAT_RST[PMC_STAT_STBY_BIT];
      det_flag_r  <= PMC_STAT_RST[PMC_STAT_DET_BIT];
      wp_cfg_r    <= PMC_STAT_RST[PMC_STAT_WPCFG_LSB +: WAKE_N];
    end else begin
      wake_flag_r <= wake_flag_nxt;
      stby_flag_r <= stby_flag_nxt;
      det_flag_r  <= det_flag_nxt;
      wp_cfg_r    <= wp_cfg_nxt;
    end
  end

  // Delay the wake flag clear so it lands two clocks after the write.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wclr_pipe_r <= '0;
    end else begin
      wclr_pipe_r <= {wclr_pipe_r[PMC_WCLR_DELAY-2:0], wclr_req};
    end
  end

  // Bus slave: one wait state per access, two for a status read.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wait_cnt_r <= 2'h0;
      pready_r   <= 1'b0;
      pslverr_r  <= 1'b0;
      prdata_r   <= PMC_STAT_RST;
    end else if (acc_done) begin
      wait_cnt_r <= 2'h0;
      pready_r   <= 1'b1;
      pslverr_r  <= ~hit_any;
      prdata_r   <= i_pwrite ? PMC_STAT_RST : rd_mux;
    end else if (acc_phase) begin
      wait_cnt_r <= wait_cnt_r + 2'h1;
      pready_r   <= 1'b0;
      pslverr_r  <= 1'b0;
    end else begin
      wait_cnt_r <= 2'h0;
      pready_r   <= 1'b0;
      pslverr_r  <= 1'b0;
    end
  end

  // Entry strobes and the wake request are registered for clean outputs.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stop_entry_r <= 1'b0;
      stby_entry_r <= 1'b0;
      wake_req_r   <= 1'b0;
    end else begin
      stop_entry_r <= enter_stop;
      stby_entry_r <= enter_stby;
      wake_req_r   <= wake_event;
    end
  end

  assign o_prdata              = prdata_r;
  assign o_pready              = pready_r;
  assign o_pslverr             = pslverr_r;
  assign o_regulator_lowpower  = lp_sel_r;
  assign o_stop_entry          = stop_entry_r;
  assign o_standby_entry       = stby_entry_r;
  assign o_detector_enable     = det_en_r;
  assign o_detector_threshold  = det_thr_r;
  assign o_backup_write_enable = bk_we_r;
  assign o_wake_pin_enable     = wp_cfg_r;
  assign o_wake_request        = wake_req_r;

endmodule // pmc_regs
`default_nettype wire

// file: test/pmc_regs_props.sv
// Purpose: Concurrent checks on the power mode register bank ports.
// Assumes: Single clock domain, asynchronous active-low reset.
// Notes:   Watches only the bank's ports, inputs and outputs alike.
`timescale 1ns/1ps
`default_nettype none
module pmc_regs_props
  import pmc_pkg::*;
#(
  parameter int unsigned WAKE_N = 8
) (
  input wire logic                    i_clk,
  input wire logic                    i_rst_n,
  input wire logic                    i_psel,
  input wire logic                    i_penable,
  input wire logic                    i_pwrite,
  input wire logic [PMC_ADDR_W-1:0]   i_paddr,
  input wire logic [PMC_DATA_W-1:0]   i_pwdata,
  input wire logic [PMC_DATA_W-1:0]   o_prdata,
  input wire logic                    o_pready,
  input wire logic                    o_pslverr,
  input wire logic                    i_system_reset,
  input wire logic                    i_standby_wake,
  input wire logic                    i_core_deep_sleep_select,
  input wire logic                    i_wait_exec,
  input wire logic                    i_alarm_wake,
  input wire logic                    o_regulator_lowpower,
  input wire logic                    o_stop_entry,
  input wire logic                    o_standby_entry,
  input wire logic                    o_detector_enable,
  input wire logic [PMC_THR_W-1:0]    o_detector_threshold,
  input wire logic                    o_backup_write_enable,
  input wire logic [WAKE_N-1:0]       o_wake_pin_enable,
  input wire logic                    o_wake_request
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  wire logic [5:0] ctl_o = {o_regulator_lowpower, o_detector_enable, o_detector_threshold,
                            o_backup_write_enable};
  wire logic [5:0] ctl_d = {i_pwdata[0], i_pwdata[4], i_pwdata[7:5], i_pwdata[8]};
  wire logic       wr_c  = i_psel && i_penable && i_pwrite && !o_pready && i_paddr == 8'h00;
  wire logic       unmap = i_paddr != PMC_CTRL_OFS && i_paddr != PMC_STAT_OFS;
  wire logic       slp   = i_wait_exec && i_core_deep_sleep_select;

  stat_read_a: assert property ($rose(i_penable) && i_psel && !i_pwrite
    && i_paddr == PMC_STAT_OFS |-> !o_pready ##1 !o_pready ##1 o_pready)
    else $error("status read not stretched by one cycle");
  ready_pulse_a: assert property (o_pready |=> !o_pready)
    else $error("ready held longer than one cycle");
  ctrl_write_a: assert property (wr_c |=> ctl_o == $past(ctl_d))
    else $error("control outputs do not follow written data");
  sys_reset_a: assert property (i_system_reset |=> ctl_o == 6'h00 && o_wake_pin_enable == '0)
    else $error("system reset left control or pin enables set");
  sb_wake_a: assert property (i_standby_wake |=> ctl_o == 6'h00)
    else $error("standby wake left control set");
  standby_pulse_a: assert property (o_standby_entry |-> $past(slp))
    else $error("standby entry without wait in deep sleep");
  stop_pulse_a: assert property (o_stop_entry |-> $past(slp) || $past(slp, 2))
    else $error("stop entry without wait in deep sleep");
  unmapped_a: assert property (o_pready && i_psel && unmap |-> o_pslverr && o_prdata == '0)
    else $error("unmapped access not refused");
  wake_req_a: assert property ($rose(i_alarm_wake) |-> ##[1:3] o_wake_request)
    else $error("alarm did not raise wake request");

  c_stat: cover property ($rose(i_penable) && i_psel && i_paddr == PMC_STAT_OFS);
  c_sb: cover property (o_standby_entry);
  c_err: cover property (o_pslverr);
endmodule // pmc_regs_props
`default_nettype wire

// file: test/pmc_core_model.sv
// Purpose: Processor side of the peripheral bus, issuing word accesses.
// Assumes: One access at a time, signals moved 1 ns after the edge.
// Notes:   Released lines show the inverse of their last value.
`timescale 1ns/1ps
`default_nettype none
module pmc_core_model (
  input  wire logic        i_clk,
  input  wire logic        i_pready,
  input  wire logic        i_pslverr,
  input  wire logic [31:0] i_prdata,
  output var  logic        o_psel,
  output var  logic        o_penable,
  output var  logic        o_pwrite,
  output var  logic [7:0]  o_paddr,
  output var  logic [31:0] o_pwdata
);
  initial begin
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_pwrite = 1'b0;
    o_paddr = 8'h00;
    o_pwdata = 32'h00000000;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic er);
    int n;
    @(posedge i_clk);
    #1;
    {o_psel, o_pwrite, o_paddr, o_pwdata, o_penable} = {1'b1, w, a, d, 1'b0};
    @(posedge i_clk);
    #1;
    o_penable = 1'b1;
    n = 0;
    // Wait states are accepted until ready or 20 clocks have passed.
    do begin
      @(posedge i_clk);
      n++;
    end while (i_pready !== 1'b1 && n < 20);
    r = i_prdata;
    er = i_pslverr;
    #1;
    {o_psel, o_penable, o_paddr, o_pwdata} = {2'b00, ~a, ~d};
  endtask
endmodule // pmc_core_model
`default_nettype wire

// file: test/tb_pmc_regs.sv
// Purpose: Self-checking bench for the power mode register bank.
// Assumes: Bus traffic comes from the core model by task calls.
// Notes:   Inputs change 1 ns after the rising edge.
`timescale 1ns/1ps
`default_nettype none
module tb_pmc_regs;
  import pmc_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, sysr = 1'b0, sbw = 1'b0, dss = 1'b0, wex = 1'b0;
  logic alarm = 1'b0, below = 1'b1;
  logic [7:0]  pin = 8'h00, paddr, wpe;
  logic [31:0] pwdata, prdata;
  logic        psel, pen, pwr, prdy, perr, lp, st, sb, den, bkwe, wreq;
  logic [2:0]  thr;
  int          fails = 0, checks = 0, n_sb = 0, n_st = 0;

  always #5 clk = ~clk;
  always @(posedge clk) begin
    n_sb += int'(sb);
    n_st += int'(st);
  end

  pmc_core_model i_pmc_core_model (.i_clk(clk), .i_pready(prdy), .i_pslverr(perr),
    .i_prdata(prdata), .o_psel(psel), .o_penable(pen), .o_pwrite(pwr), .o_paddr(paddr),
    .o_pwdata(pwdata));
  pmc_regs #(.WAKE_N(8)) i_pmc_regs (.i_clk(clk), .i_rst_n(rst_n), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(prdy), .o_pslverr(perr), .i_system_reset(sysr), .i_standby_wake(sbw),
    .i_core_deep_sleep_select(dss), .i_wait_exec(wex), .i_wake_pin(pin),
    .i_alarm_wake(alarm), .i_detector_below(below), .o_regulator_lowpower(lp),
    .o_stop_entry(st), .o_standby_entry(sb), .o_detector_enable(den),
    .o_detector_threshold(thr), .o_backup_write_enable(bkwe), .o_wake_pin_enable(wpe),
    .o_wake_request(wreq));

  task automatic end_of_test;
    if (fails == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        er;
    i_pmc_core_model.xfer(1'b1, a, d, r, er);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] r;
    logic        er;
    i_pmc_core_model.xfer(1'b0, a, 32'h00000000, r, er);
    chk(nm, e, r);
    chk("slverr", {31'h0, a != PMC_CTRL_OFS && a != PMC_STAT_OFS}, {31'h0, er});
  endtask
  task automatic wait_exec;
    wex = 1'b1;
    tick(1);
    wex = 1'b0;
    tick(4);
  endtask

  initial begin
    #100us;
    fails++;
    end_of_test();
  end

  initial begin
    tick(12);
    rst_n = 1'b1;
    tick(3);
    rd(8'h00, 32'h00000000, "ctrl_rst");
    rd(8'h04, 32'h00000000, "stat_rst");
    chk("bkwe_rst", 32'h0, {31'h0, bkwe});
    wr(8'h00, 32'hFFFFFFFF);
    rd(8'h00, 32'h000001F3, "ctrl_all");
    chk("ctl_out", 32'h3F, {26'h0, lp, den, thr, bkwe});
    for (int t = 0; t < 8; t++) begin
      wr(8'h00, 32'(t) << 5);
      chk("thr", 32'(t), {29'h0, thr});
    end
    wr(8'h08, 32'hFFFFFFFF);
    rd(8'h08, 32'h00000000, "unmapped");
    rd(8'h00, 32'h000000E0, "ctrl_keep");
    below = 1'b0;
    pin = 8'h08;
    tick(6);
    rd(8'h04, 32'h00000000, "pin_off");
    wr(8'h04, 32'hFFFFFFFF);
    tick(6);
    rd(8'h04, 32'h0000FF01, "pin_on");
    chk("wpe", 32'hFF, {24'h0, wpe});
    pin = 8'h00;
    wr(8'h00, 32'h00000004);
    rd(8'h04, 32'h0000FF00, "wclr");
    alarm = 1'b1;
    tick(6);
    rd(8'h04, 32'h0000FF01, "alarm");
    alarm = 1'b0;
    below = 1'b1;
    wr(8'h00, 32'h00000016);
    rd(8'h04, 32'h0000FF04, "det");
    dss = 1'b1;
    wait_exec();
    chk("sb_cnt", 32'd1, 32'(n_sb));
    rd(8'h04, 32'h0000FF06, "sb_flag");
    sbw = 1'b1;
    tick(1);
    sbw = 1'b0;
    rd(8'h00, 32'h00000000, "ctrl_wake");
    rd(8'h04, 32'h0000FF02, "stat_wake");
    wr(8'h00, 32'h00000000);
    rd(8'h04, 32'h0000FF02, "sclr0");
    wr(8'h00, 32'h00000008);
    rd(8'h04, 32'h0000FF00, "sclr1");
    pin = 8'h01;
    tick(6);
    pin = 8'h00;
    wr(8'h00, 32'h00000002);
    wait_exec();
    chk("sb_rej", 32'd1, 32'(n_sb));
    wr(8'h00, 32'h00000005);
    wait_exec();
    chk("st_cnt", 32'd1, 32'(n_st));
    chk("lp", 32'h1, {31'h0, lp});
    dss = 1'b0;
    sysr = 1'b1;
    tick(1);
    sysr = 1'b0;
    rd(8'h04, 32'h00000000, "sysrst");
    end_of_test();
  end
endmodule // tb_pmc_regs

bind pmc_regs pmc_regs_props #(.WAKE_N(WAKE_N)) i_pmc_regs_props (.*);
`default_nettype wire
